//--- design/hbs_bridge.sv
`timescale 1ns/1ps
module hbs_bridge
(
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // reset straps, levels of the memory address lines
  input wire hbs_pkg::hbs_strap_t straps,
  output hbs_pkg::hbs_cfg_t cfg,
  // pci arbitration, active low
  input wire logic [4:0] pci_req_b,
  output logic [4:0] pci_gnt_b,
  input wire logic pci_frame_b,
  input wire logic pci_irdy_b,
  // clock-run open drain
  input wire logic clkrun_b_in,
  output logic clkrun_b_out,
  output logic clkrun_b_oe,
  output logic pci_clk_run,
  // configuration cycle request, mechanism one
  input wire logic cfg_req,
  input wire logic [4:0] cfg_dev,
  output logic cfg_ack,
  output logic cfg_err,
  output logic [31:0] cfg_idsel,
  // clock gating
  input wire logic gclk_en,
  input wire logic cpu_active,
  output logic core_clk_gate,
  // sdram bank clock enables
  input wire logic [5:0] bank_active,
  output logic [5:0] sdram_cke
);
  logic started;
  logic [2:0] last_gnt;
  logic [3:0] pick;
  logic [2:0] next_owner;
  logic next_valid;
  logic bus_busy;
  logic [3:0] idle_cnt;

  // find next requester after the last owner
  function automatic logic [3:0] rr_pick(input logic [4:0] req,
                                         input logic [2:0] last);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = 1; i <= 5; i++)
    begin
      idx = 3'((int'(last) + i) % 5);
      if (req[idx] && !res[3])
        res = {1'b1, idx};
    end
    return res;
  endfunction

  // capture straps once after reset release
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      started <= 1'b0;
      cfg <= hbs_pkg::CFG_RST;
    end
    else if (clk_en && !started)
    begin
      started <= 1'b1;
      cfg.freq_100 <= straps.host_freq_select_strap;
      cfg.ioq_depth <= straps.queue_depth_strap ?
        4'(hbs_pkg::IOQ_MIN) : 4'(hbs_pkg::IOQ_MAX);
      cfg.quick_idle <= straps.idle_state_select_strap;
      cfg.gfx_en <= !straps.graphics_port_disable_strap;
      cfg.std_module <= !straps.module_config_strap;
      cfg.mobile_buf <= straps.host_buffer_mode_strap;
    end
  end

  // round-robin winner among requesters
  always_comb
  begin
    pick = rr_pick(~pci_req_b, last_gnt);
    next_owner = pick[2:0];
    next_valid = pick[3];
  end

  assign bus_busy = !pci_frame_b || !pci_irdy_b;

  // grant one master at a time, re-arbitrate while bus idle
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      pci_gnt_b <= 5'h1f;
      last_gnt <= 3'h4;
    end
    else if (clk_en && !bus_busy)
    begin
      if (next_valid)
      begin
        pci_gnt_b <= ~(5'h01 << next_owner);
        last_gnt <= next_owner;
      end
      else
        pci_gnt_b <= 5'h1f;
    end
  end

  // keep pci clock running while any agent pulls clock-run
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      pci_clk_run <= 1'b1;
    else if (clk_en)
      pci_clk_run <= !clkrun_b_in || bus_busy || (pci_req_b != 5'h1f);
  end
  assign clkrun_b_out = 1'b0;
  assign clkrun_b_oe = 1'b0;

  // config cycle idsel decode
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      cfg_ack <= 1'b0;
      cfg_err <= 1'b0;
      cfg_idsel <= 32'h0;
    end
    else if (clk_en)
    begin
      cfg_ack <= cfg_req;
      cfg_err <= 1'b0;
      cfg_idsel <= 32'h0;
      if (cfg_req)
      begin
        if (cfg_dev < hbs_pkg::IDSEL_FIRST_DEV)
          cfg_err <= 1'b1;
        else
          cfg_idsel <= 32'h1 << cfg_dev;
      end
    end
  end

  // idle counter for internal clock gating
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      idle_cnt <= hbs_pkg::IDLE_RST;
    else if (clk_en)
    begin
      if (cpu_active || bus_busy || !gclk_en)
        idle_cnt <= hbs_pkg::IDLE_RST;
      else if (idle_cnt != hbs_pkg::IDLE_CYC_W)
        idle_cnt <= idle_cnt + 4'h1;
    end
  end
  // wake at once on activity
  assign core_clk_gate = gclk_en && !cpu_active && !bus_busy
    && idle_cnt == hbs_pkg::IDLE_CYC_W;

  // one clock enable per bank, shared control set
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
      sdram_cke <= 6'h00;
    else if (clk_en)
      sdram_cke <= bank_active;
  end

  // strap capture then held
  property p_cfg_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      started && $past(started) |-> $stable(cfg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("cfg changed");

  property p_one_grant;
    @(posedge sys_clk) disable iff (!rst_b)
      $countones(~pci_gnt_b) <= 1;
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("two grants");

  property p_no_low_idsel;
    @(posedge sys_clk) disable iff (!rst_b)
      cfg_idsel[12:0] == 13'h0;
  endproperty
  a_no_low_idsel: assert property (p_no_low_idsel)
    else $error("ad11 or ad12 as idsel");

  property p_cfg_ack;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && cfg_req && cfg_dev >= 5'h0d |=> cfg_ack && !cfg_err;
  endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("cfg not acked");

  property p_clkrun;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && !clkrun_b_in |=> pci_clk_run;
  endproperty
  a_clkrun: assert property (p_clkrun) else $error("clkrun ignored");

  property p_gate;
    @(posedge sys_clk) disable iff (!rst_b)
      core_clk_gate |-> gclk_en && !cpu_active;
  endproperty
  a_gate: assert property (p_gate) else $error("gated while active");

  property p_cke;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en |=> sdram_cke == $past(bank_active);
  endproperty
  a_cke: assert property (p_cke) else $error("cke mismatch");

  property p_gfx;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && !started
      |=> cfg.gfx_en == !$past(straps.graphics_port_disable_strap);
  endproperty
  a_gfx: assert property (p_gfx) else $error("gfx strap");

  // host frequency taken from its strap
  property p_freq;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && !started
      |=> cfg.freq_100 == $past(straps.host_freq_select_strap);
  endproperty
  a_freq: assert property (p_freq) else $error("freq strap");

  // unstrapped queue line gives the deepest queue
  property p_ioq;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && !started && !straps.queue_depth_strap
      |=> cfg.ioq_depth == 4'(hbs_pkg::IOQ_MAX);
  endproperty
  a_ioq: assert property (p_ioq) else $error("queue depth");

  // arbitration steps: request on an idle bus, then a grant
  sequence s_arb_req;
    clk_en && pci_frame_b && pci_irdy_b && pci_req_b != 5'h1f;
  endsequence

  sequence s_granted;
    pci_gnt_b != 5'h1f;
  endsequence

  // a request on an idle bus is granted the next cycle
  property p_grant;
    @(posedge sys_clk) disable iff (!rst_b)
      s_arb_req |=> s_granted;
  endproperty
  a_grant: assert property (p_grant) else $error("no grant");

  // the grant goes to a master that was requesting
  property p_grant_req;
    @(posedge sys_clk) disable iff (!rst_b)
      s_arb_req |=> (~pci_gnt_b & ~$past(pci_req_b)) != 5'h00;
  endproperty
  a_grant_req: assert property (p_grant_req)
    else $error("grant to idle master");

  // grant stands while the bus is busy
  property p_grant_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && bus_busy |=> $stable(pci_gnt_b);
  endproperty
  a_grant_hold: assert property (p_grant_hold)
    else $error("grant moved while busy");

  // low device numbers refused, no idsel line raised
  property p_cfg_err;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && cfg_req && cfg_dev < hbs_pkg::IDSEL_FIRST_DEV
      |=> cfg_err && cfg_idsel == 32'h0;
  endproperty
  a_cfg_err: assert property (p_cfg_err)
    else $error("low device not refused");

  // an accepted cycle raises exactly one idsel line
  property p_idsel_onehot;
    @(posedge sys_clk) disable iff (!rst_b)
      cfg_ack && !cfg_err |-> $onehot(cfg_idsel);
  endproperty
  a_idsel_onehot: assert property (p_idsel_onehot)
    else $error("idsel not one-hot");

  // no request, no acknowledge and no idsel
  property p_cfg_quiet;
    @(posedge sys_clk) disable iff (!rst_b)
      clk_en && !cfg_req |=> !cfg_ack && cfg_idsel == 32'h0;
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("stray config cycle");

  // pci clock may stop once nobody wants it
  sequence s_pci_quiet;
    clk_en && clkrun_b_in && !bus_busy && pci_req_b == 5'h1f;
  endsequence

  property p_clk_stop;
    @(posedge sys_clk) disable iff (!rst_b)
      s_pci_quiet |=> !pci_clk_run;
  endproperty
  a_clk_stop: assert property (p_clk_stop)
    else $error("pci clock kept needlessly");

  // gating steps: quiet cycles, then the clock stops
  sequence s_idle;
    clk_en && gclk_en && !cpu_active && !bus_busy;
  endsequence

  property p_gate_on;
    @(posedge sys_clk) disable iff (!rst_b)
      s_idle [*6] |-> core_clk_gate;
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("clock not gated when idle");

  // activity or a cleared enable wakes at once
  property p_gate_wake;
    @(posedge sys_clk) disable iff (!rst_b)
      cpu_active || !gclk_en |-> !core_clk_gate;
  endproperty
  a_gate_wake: assert property (p_gate_wake)
    else $error("clock gated while enable off");

  // low clock enable freezes the held state
  property p_freeze;
    @(posedge sys_clk) disable iff (!rst_b)
      !clk_en |=> $stable(cfg) && $stable(pci_gnt_b)
        && $stable(sdram_cke) && $stable(cfg_idsel);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");
endmodule

//--- design/hbs_pkg.sv
// Behaviour
// - high strap on host frequency line at reset selects 100 MHz host
// - queue depth strap unstrapped gives maximum in-order queue of 8
// - high idle select strap chooses low-latency idle clock state
// - graphics port enabled unless board straps disable line high
// - unstrapped module config line selects standard module configuration
// - high buffer mode strap selects mobile host bus buffers
// - arbitrate pci bus among five masters, one request/grant pair each
// - agents pull shared clock-run line; device honours by keeping clock
// - config cycles by mechanism one, idsel from ad lines 31 to 11
// - device is number zero, never asserts ad11 as idsel
// - ad12 kept for graphics bus; first external idsel is ad13
// - with gating enabled, stop internal clock when no cpu/pci activity
// - one sdram control set, six banks, one clock enable per bank
// - no eight banks, 256-Mb parts, second address set, edo, 66 MHz
package hbs_pkg;
  localparam int NUM_MASTERS = 5;
  localparam int NUM_BANKS = 6;
  localparam int IOQ_MAX = 8;
  localparam int IOQ_MIN = 1;
  localparam logic [4:0] IDSEL_FIRST_DEV = 5'h0d;
  localparam logic [4:0] IDSEL_LAST_DEV = 5'h1f;
  localparam logic [4:0] IDSEL_GFX_DEV = 5'h0c;
  localparam logic [4:0] IDSEL_SELF_DEV = 5'h0b;
  localparam logic [4:0] IDSEL_SB_REC_DEV = 5'h12;
  // idle cycles before the internal clock is gated
  localparam int IDLE_NS = 200;
  localparam int CLK_NS = 40;
  localparam int IDLE_CYC = (IDLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] IDLE_CYC_W = 4'(IDLE_CYC);
  localparam logic [3:0] IDLE_RST = 4'h0;

  typedef struct packed {
    logic freq_100;
    logic [3:0] ioq_depth;
    logic quick_idle;
    logic gfx_en;
    logic std_module;
    logic mobile_buf;
  } hbs_cfg_t;

  localparam hbs_cfg_t CFG_RST = '{1'b1, 4'h8, 1'b1, 1'b1, 1'b1, 1'b1};

  typedef struct packed {
    logic host_freq_select_strap;
    logic queue_depth_strap;
    logic idle_state_select_strap;
    logic graphics_port_disable_strap;
    logic module_config_strap;
    logic host_buffer_mode_strap;
  } hbs_strap_t;
endpackage

//--- verification/hbs_pci_agents.sv
`timescale 1ns/1ps
module hbs_pci_agents
(
  // clock and demand
  input wire logic sys_clk,
  input wire logic [4:0] want,
  // arbitration and bus
  input wire logic [4:0] gnt_b,
  output logic [4:0] req_b,
  output logic frame_b,
  output logic irdy_b,
  output logic clkrun_b
);
  logic [1:0] ph = 2'h0;
  // address then data phase once a requester is granted
  always @(posedge sys_clk)
  begin
    if (ph == 2'h0)
      ph <= ((~gnt_b & ~req_b) != 5'h00) ? 2'h1 : 2'h0;
    else
      ph <= (ph == 2'h1) ? 2'h2 : 2'h0;
  end
  // levels seen on the bus
  assign req_b = ~want;
  assign frame_b = (ph != 2'h1);
  assign irdy_b = (ph == 2'h0);
  assign clkrun_b = (want == 5'h00);
endmodule

//--- verification/tb_host_bridge_straps_pci_config.sv
`timescale 1ns/1ps
module tb_host_bridge_straps_pci_config;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  hbs_pkg::hbs_strap_t straps = '0;
  hbs_pkg::hbs_cfg_t cfg, c0;
  logic [4:0] want = 5'h00, gnt_b, req_b, seen = 5'h00;
  logic frame_b, irdy_b, ck_b, od, oe, line, run, r, gate;
  logic cfg_req = 1'b0, ack, err, gclk_en = 1'b0, cpu_active = 1'b1;
  logic en = 1'b1;
  logic [4:0] cfg_dev = 5'h00;
  logic [31:0] idsel;
  logic [5:0] bank_active = 6'h00, cke, b;
  int miscompares = 0, checked = 0;
  // clock and resolved open-drain wire
  always #20 sys_clk = ~sys_clk;
  assign line = ck_b & ~(oe & ~od);
  hbs_bridge uut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(en),
    .straps(straps), .cfg(cfg), .pci_req_b(req_b), .pci_gnt_b(gnt_b),
    .pci_frame_b(frame_b), .pci_irdy_b(irdy_b), .clkrun_b_in(line),
    .clkrun_b_out(od), .clkrun_b_oe(oe), .pci_clk_run(run),
    .cfg_req(cfg_req), .cfg_dev(cfg_dev), .cfg_ack(ack), .cfg_err(err),
    .cfg_idsel(idsel), .gclk_en(gclk_en), .cpu_active(cpu_active),
    .core_clk_gate(gate), .bank_active(bank_active), .sdram_cke(cke));
  hbs_pci_agents agents (.sys_clk(sys_clk), .want(want), .gnt_b(gnt_b),
    .req_b(req_b), .frame_b(frame_b), .irdy_b(irdy_b), .clkrun_b(ck_b));
  // masters ever granted
  always @(posedge sys_clk)
    seen <= seen | ~gnt_b;
  // expected capture of the straps
  function automatic hbs_pkg::hbs_cfg_t exp_cfg(hbs_pkg::hbs_strap_t s);
    hbs_pkg::hbs_cfg_t c;
    c.freq_100 = s.host_freq_select_strap;
    c.ioq_depth = s.queue_depth_strap ? 4'h1 : 4'h8;
    c.quick_idle = s.idle_state_select_strap;
    c.gfx_en = ~s.graphics_port_disable_strap;
    c.std_module = ~s.module_config_strap;
    c.mobile_buf = s.host_buffer_mode_strap;
    return c;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'hb604d94d));
    straps = hbs_pkg::hbs_strap_t'($urandom);
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk("cfg_rst", cfg, hbs_pkg::CFG_RST);
    c0 = exp_cfg(straps);
    repeat (2) @(posedge sys_clk);
    straps <= ~straps;
    repeat (3) @(posedge sys_clk);
    #1 chk("cfg", cfg, c0);
    for (int d = 0; d < 32; d++)
    begin
      @(posedge sys_clk);
      cfg_req <= 1'b1;
      cfg_dev <= 5'(d);
      @(posedge sys_clk);
      cfg_req <= 1'b0;
      #1 chk("ack", ack, 1'b1);
      chk("err", err, d < 13);
      chk("idsel", idsel, d < 13 ? 32'h0 : 32'h1 << d);
      if (5'(d) == hbs_pkg::IDSEL_SB_REC_DEV)
        chk("sb_idsel", idsel[18], 1'b1);
    end
    chk("run_idle", run, 1'b0);
    for (int i = 0; i < 240; i++)
    begin
      @(posedge sys_clk);
      b = bank_active;
      r = ~line | ~frame_b | ~irdy_b | (req_b != 5'h1f);
      want <= (i > 200) ? 5'h1f : 5'($urandom);
      bank_active <= 6'($urandom);
      #1 chk("cke", cke, b);
      chk("run", run, r);
    end
    chk("masters", seen, 5'h1f);
    @(posedge sys_clk);
    want <= 5'h00;
    gclk_en <= 1'b1;
    cpu_active <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 chk("gate", gate, 1'b1);
    @(posedge sys_clk);
    cpu_active <= 1'b1;
    #1 chk("gate_busy", gate, 1'b0);
    @(posedge sys_clk);
    cpu_active <= 1'b0;
    gclk_en <= 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 chk("gate_off", gate, 1'b0);
    @(posedge sys_clk);
    en <= 1'b0;
    bank_active <= ~bank_active;
    #1 b = cke;
    repeat (3) @(posedge sys_clk);
    #1 chk("cke_frozen", cke, b);
    en <= 1'b1;
    rst_b <= 1'b0;
    straps <= hbs_pkg::hbs_strap_t'(6'h00);
    repeat (2) @(posedge sys_clk);
    #1 chk("cfg_rst2", cfg, hbs_pkg::CFG_RST);
    rst_b <= 1'b1;
    c0 = exp_cfg(straps);
    repeat (2) @(posedge sys_clk);
    #1 chk("cfg2", cfg, c0);
    summarize();
  end
  // watchdog
  initial
  begin
    #60000;
    miscompares++;
    summarize();
  end
endmodule
